// file: asp_serial_port.sv
// Purpose: Async serial port with FIFOs, wake-up modes and rate detect
// Assumes: clk_i is the low speed peripheral clock; rx pin is asynchronous
// Notes: Read data appears one cycle after rd_i; a read of data pops it
`timescale 1ns/1ns
module asp_serial_port
  import asp_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] wdata_i,
  output logic [15:0] rdata_o,
  input wire logic serial_rx_pin_i,
  output logic serial_tx_pin_o,
  output logic rx_int_o,
  output logic tx_int_o
);
  typedef enum logic {ASP_TX_IDLE, ASP_TX_SHIFT} asp_tx_type;
  typedef enum logic {ASP_RX_IDLE, ASP_RX_BITS} asp_rx_type;
  typedef struct packed {
    logic [7:0] ccr;
    logic [7:0] ctl1;
    logic [15:0] rate_divisor;
    logic [1:0] ctl2;
    logic [7:0] pri;
    logic ffen;
    logic abden;
    logic abdf;
    logic s1;
    logic s2;
    logic [15:0] pcnt;
    asp_tx_type tst;
    logic [2:0] ttk;
    logic [3:0] tn;
    logic [12:0] tsh;
    logic [3:0][7:0] txq;
    logic [1:0] twp;
    logic [1:0] trp;
    logic [2:0] tcn;
    asp_rx_type rst;
    logic [2:0] rtk;
    logic [3:0] rbit;
    logic [12:0] rsh;
    logic idle_seen;
    logic [7:0] icnt;
    logic [3:0][7:0] rxq;
    logic [1:0] rwp;
    logic [1:0] rrp;
    logic [2:0] rcn;
    logic pe;
    logic oe;
    logic fe;
    logic brk;
    logic wake;
    logic ovf;
    logic ameas;
    logic [18:0] acnt;
    logic [15:0] rdata;
    logic txo;
    logic rxint;
    logic txint;
  } asp_state_type;

  asp_state_type s;
  asp_state_type next_s;

  function automatic logic [3:0] asp_frame_len(input logic [7:0] c);
    asp_frame_len = 4'(c[2:0]) + 4'h3 + 4'(c[ASP_CCR_ADDRMODE]) + 4'(c[ASP_CCR_PAREN])
      + 4'(c[ASP_CCR_STOP2]);
  endfunction

  function automatic logic [7:0] asp_mask(input logic [7:0] d, input logic [2:0] lm1);
    asp_mask = d & 8'((9'h2 << lm1) - 9'h1);
  endfunction

  logic tick;
  logic [2:0] cap;
  logic [3:0] nlen;
  logic [7:0] txd;
  logic [12:0] fr;
  logic [3:0] pos;
  logic [7:0] rd;
  logic [3:0] sp;
  logic [12:0] rf;
  logic low_all;
  logic rx_fe;
  logic rx_pe;
  logic rx_addr;
  logic pop_rx;
  logic push_tx;
  logic rx_buffer_ready_flag;
  logic tx_buffer_ready_flag;
  logic txempty;
  logic rxerr;

  always_comb begin
    next_s = s;
    tick = 1'b0;
    fr = '1;
    pos = 4'h0;
    rd = 8'h00;
    sp = 4'h0;
    rf = s.rsh;
    low_all = 1'b1;
    rx_fe = 1'b0;
    rx_pe = 1'b0;
    rx_addr = 1'b0;
    nlen = asp_frame_len(s.ccr);
    // R16 fifo depth
    cap = s.ffen ? ASP_FIFO_DEPTH : 3'h1;
    txd = asp_mask(s.txq[s.trp], s.ccr[2:0]);
    next_s.s1 = serial_rx_pin_i;
    next_s.s2 = s.s1;
    // R1 bit rate divider
    if (s.pcnt >= ((s.rate_divisor == 16'h0000) ? 16'h0001 : s.rate_divisor)) begin
      tick = 1'b1;
      next_s.pcnt = 16'h0000;
    end else begin
      next_s.pcnt = s.pcnt + 16'h0001;
    end
    pop_rx = 1'b0;
    push_tx = 1'b0;
    next_s.rdata = 16'h0000;
    // R13 low byte only
    if (rd_i) begin
      unique case (addr_i)
        ASP_COMMS_CONTROL: next_s.rdata[7:0] = s.ccr;
        ASP_CONTROL_ONE: next_s.rdata[7:0] = s.ctl1;
        ASP_BAUD_HIGH: next_s.rdata[7:0] = s.rate_divisor[15:8];
        ASP_BAUD_LOW: next_s.rdata[7:0] = s.rate_divisor[7:0];
        // R9 status flags
        ASP_CONTROL_TWO: next_s.rdata[7:0] = {tx_buffer_ready_flag, txempty, 4'h0, s.ctl2};
        // R10 R11 status flags
        ASP_RX_STATUS: next_s.rdata[7:0] = {rxerr, rx_buffer_ready_flag, s.brk, s.fe, s.oe, s.pe, s.wake, 1'b0};
        ASP_RX_EMU: next_s.rdata[7:0] = s.rxq[s.rrp];
        ASP_RX_DATA: begin
          next_s.rdata[7:0] = s.rxq[s.rrp];
          pop_rx = rx_buffer_ready_flag;
        end
        ASP_TX_DATA: next_s.rdata[7:0] = s.txq[s.twp - 2'h1];
        ASP_FIFO_TX: next_s.rdata[7:0] = {1'b0, s.ffen, 3'h0, s.tcn};
        ASP_FIFO_RX: next_s.rdata[7:0] = {s.ovf, 4'h0, s.rcn};
        ASP_FIFO_CT: next_s.rdata[7:0] = {s.abdf, 1'b0, s.abden, 5'h00};
        ASP_PRIORITY: next_s.rdata[7:0] = s.pri;
        default: next_s.rdata = 16'h0000;
      endcase
    end
    if (wr_i) begin
      unique case (addr_i)
        ASP_COMMS_CONTROL: next_s.ccr = wdata_i[7:0];
        ASP_CONTROL_ONE: next_s.ctl1 = wdata_i[7:0];
        ASP_BAUD_HIGH: next_s.rate_divisor[15:8] = wdata_i[7:0];
        ASP_BAUD_LOW: next_s.rate_divisor[7:0] = wdata_i[7:0];
        ASP_CONTROL_TWO: next_s.ctl2 = wdata_i[1:0];
        ASP_TX_DATA: push_tx = tx_buffer_ready_flag;
        ASP_FIFO_TX: next_s.ffen = wdata_i[ASP_FF_EN];
        ASP_FIFO_RX: next_s.ovf = s.ovf & ~wdata_i[ASP_FF_CLR];
        ASP_FIFO_CT: begin
          next_s.abden = wdata_i[ASP_ABD_EN];
          next_s.abdf = s.abdf & ~wdata_i[ASP_FF_CLR];
        end
        ASP_PRIORITY: next_s.pri = wdata_i[7:0];
        default: next_s.pri = s.pri;
      endcase
    end
    // R7 transmit buffer load
    if (push_tx) begin
      next_s.txq[s.twp] = wdata_i[7:0];
      next_s.twp = s.twp + 2'h1;
      next_s.tcn = next_s.tcn + 3'h1;
    end
    if (pop_rx) begin
      next_s.rrp = s.rrp + 2'h1;
      next_s.rcn = next_s.rcn - 3'h1;
    end
    // R2 R3 R18 build transmit frame
    fr[0] = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i <= int'(s.ccr[2:0])) begin
        fr[i + 1] = txd[i];
      end
    end
    pos = 4'(s.ccr[2:0]) + 4'h2;
    // R6 address bit on transmit
    if (s.ccr[ASP_CCR_ADDRMODE]) begin
      fr[pos] = s.ctl1[ASP_CTL1_TXWAKE];
      pos = pos + 4'h1;
    end
    if (s.ccr[ASP_CCR_PAREN]) begin
      fr[pos] = (^txd) ^ s.ccr[ASP_CCR_ODD];
    end
    unique case (s.tst)
      ASP_TX_IDLE: begin
        // R8 transmit enable
        if (tick && s.ctl1[ASP_CTL1_TXEN] && s.tcn != 3'h0) begin
          next_s.tst = ASP_TX_SHIFT;
          next_s.ttk = 3'h0;
          // R6 idle-line gap before an address character
          if (!s.ccr[ASP_CCR_ADDRMODE] && s.ctl1[ASP_CTL1_TXWAKE]) begin
            next_s.tsh = '1;
            next_s.tn = ASP_IDLE_BITS;
          end else begin
            next_s.tsh = fr;
            next_s.tn = nlen;
            next_s.trp = s.trp + 2'h1;
            next_s.tcn = next_s.tcn - 3'h1;
          end
          if (!(wr_i && addr_i == ASP_CONTROL_ONE)) begin
            next_s.ctl1[ASP_CTL1_TXWAKE] = 1'b0;
          end
        end
      end
      ASP_TX_SHIFT: begin
        // R17 hold each bit for eight ticks
        if (tick) begin
          next_s.ttk = s.ttk + 3'h1;
          if (s.ttk == ASP_TICK_LAST) begin
            next_s.tsh = {1'b1, s.tsh[12:1]};
            next_s.tn = s.tn - 4'h1;
            if (s.tn == 4'h1) begin
              next_s.tst = ASP_TX_IDLE;
            end
          end
        end
      end
    endcase
    next_s.txo = (next_s.tst == ASP_TX_SHIFT) ? next_s.tsh[0] : 1'b1;
    // R6 idle-line detection
    if (s.rst == ASP_RX_IDLE && tick) begin
      if (s.s2) begin
        next_s.icnt = (s.icnt == 8'hff) ? s.icnt : s.icnt + 8'h01;
      end else begin
        next_s.icnt = 8'h00;
      end
    end
    // R2 R3 R4 decode received frame
    // Include the bit sampled in this cycle so the last stop bit is seen
    if (s.rst == ASP_RX_BITS && tick && s.rtk == ASP_TICK_CENTRE) begin
      rf[s.rbit] = s.s2;
    end
    for (int i = 0; i < 8; i++) begin
      if (i <= int'(s.ccr[2:0])) begin
        rd[i] = rf[i + 1];
      end
    end
    pos = 4'(s.ccr[2:0]) + 4'h2;
    rx_addr = s.idle_seen;
    if (s.ccr[ASP_CCR_ADDRMODE]) begin
      rx_addr = rf[pos];
      pos = pos + 4'h1;
    end
    if (s.ccr[ASP_CCR_PAREN]) begin
      rx_pe = rf[pos] != ((^rd) ^ s.ccr[ASP_CCR_ODD]);
      pos = pos + 4'h1;
    end
    sp = pos;
    rx_fe = !rf[sp] || (s.ccr[ASP_CCR_STOP2] && !rf[sp + 4'h1]);
    for (int i = 0; i < 13; i++) begin
      if (i <= int'(sp)) begin
        low_all = low_all & ~rf[i];
      end
    end
    unique case (s.rst)
      ASP_RX_IDLE: begin
        // R8 receive enable
        if (tick && !s.s2 && s.ctl1[ASP_CTL1_RXEN]) begin
          next_s.rst = ASP_RX_BITS;
          next_s.rtk = 3'h0;
          next_s.rbit = 4'h0;
          next_s.idle_seen = s.icnt >= ASP_IDLE_TICKS;
        end
      end
      ASP_RX_BITS: begin
        if (tick) begin
          next_s.rtk = s.rtk + 3'h1;
          // R19 centre sample and start check
          if (s.rtk == ASP_TICK_CENTRE) begin
            next_s.rsh[s.rbit] = s.s2;
            next_s.rbit = s.rbit + 4'h1;
            if (s.rbit == 4'h0 && s.s2) begin
              next_s.rst = ASP_RX_IDLE;
            end else if (s.rbit == nlen - 4'h1) begin
              next_s.rst = ASP_RX_IDLE;
            end
          end
        end
      end
    endcase
    // R5 R6 store character and errors
    if (s.rst == ASP_RX_BITS && next_s.rst == ASP_RX_IDLE && s.rbit != 4'h0) begin
      next_s.icnt = 8'h00;
      if (!s.ctl1[ASP_CTL1_SLEEP] || rx_addr) begin
        next_s.wake = rx_addr;
        next_s.pe = s.pe | rx_pe;
        next_s.fe = s.fe | rx_fe;
        next_s.brk = s.brk | (rx_fe & low_all);
        if (next_s.rcn >= cap) begin
          next_s.oe = 1'b1;
          next_s.ovf = next_s.ovf | s.ffen;
        end else begin
          next_s.rxq[s.rwp] = rd;
          next_s.rwp = s.rwp + 2'h1;
          next_s.rcn = next_s.rcn + 3'h1;
        end
      end
    end
    // R15 measure start bit low time
    if (s.abden && !s.abdf) begin
      if (!s.s2) begin
        next_s.ameas = 1'b1;
        next_s.acnt = (s.acnt[18]) ? s.acnt : s.acnt + 19'h00001;
      end else if (s.ameas) begin
        next_s.ameas = 1'b0;
        next_s.acnt = 19'h00000;
        next_s.abdf = 1'b1;
        next_s.rate_divisor = (s.acnt < 19'h00010) ? 16'h0000 : 16'(s.acnt[18:3] - 16'h0001);
      end
    end
    // R12 interrupt enables
    next_s.rxint = (rx_buffer_ready_flag & s.ctl2[1]) | (s.brk & (s.ctl2[1] | s.ctl1[ASP_CTL1_ERRIE]))
      | (rxerr & s.ctl1[ASP_CTL1_ERRIE]);
    next_s.txint = tx_buffer_ready_flag & s.ctl2[0];
    // Software reset clears error and wake flags, buffers and both paths
    if (!s.ctl1[ASP_CTL1_RUN]) begin
      next_s.tst = ASP_TX_IDLE;
      next_s.rst = ASP_RX_IDLE;
      next_s.txo = 1'b1;
      next_s.tcn = 3'h0;
      next_s.twp = 2'h0;
      next_s.trp = 2'h0;
      next_s.rcn = 3'h0;
      next_s.rwp = 2'h0;
      next_s.rrp = 2'h0;
      next_s.pe = 1'b0;
      next_s.oe = 1'b0;
      next_s.fe = 1'b0;
      next_s.brk = 1'b0;
      next_s.wake = 1'b0;
    end
  end

  assign rx_buffer_ready_flag = s.rcn != 3'h0;
  assign tx_buffer_ready_flag = s.tcn < cap;
  assign txempty = s.tst == ASP_TX_IDLE && s.tcn == 3'h0;
  // R11 summary error
  assign rxerr = s.pe | s.oe | s.fe | s.brk;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      s <= '0;
      s.ccr <= ASP_REG_RESET;
      s.ctl1 <= ASP_REG_RESET;
      s.s1 <= 1'b1;
      s.s2 <= 1'b1;
      s.tsh <= '1;
      s.txo <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_o = s.rdata;
  assign serial_tx_pin_o = s.txo;
  assign rx_int_o = s.rxint;
  assign tx_int_o = s.txint;
endmodule

// file: asp_pkg.sv
// Purpose: Constants and register map of the async serial port
// Assumes: 16-bit word register port, byte-wide registers in bits 7-0
// Notes: Counts are in bit rate ticks, eight a bit; ASP_IDLE_BITS is in bits
// Notes on behaviour
// R1 - Bit time is (divisor+1)*8 clocks, or 16 clocks when divisor is zero
// R2 - One start bit, then one to eight data bits
// R3 - Optional even, odd or no parity bit after the data
// R4 - One or two stop bits, checked by the receiver
// R5 - Parity, overrun, framing and break errors each have a flag
// R6 - Idle-line or address-bit wake-up tells address from data characters
// R7 - Buffer register in front of each shift register
// R8 - Independent transmit and receive enables
// R9 - Transmit buffer ready and transmitter empty flags
// R10 - Receive ready and break detected flags
// R11 - Summary receive error flag over the four error conditions
// R12 - Separate interrupt enables; break not gated by receive enable alone
// R13 - Data in bits 7-0; upper byte reads zero, writes ignored
// R14 - Software uses only 16-bit accesses
// R15 - Hardware measures incoming bit rate and loads the divisor
// R16 - 4-level transmit and receive FIFOs with their own controls
// R17 - NRZ levels held for the whole bit time on both pins
// R18 - Idle high, start low, LSB first, stop high
// R19 - Receiver samples bit centres at 8x and validates the start bit
package asp_pkg;
  localparam logic [15:0] ASP_COMMS_CONTROL = 16'h7050;
  localparam logic [15:0] ASP_CONTROL_ONE = 16'h7051;
  localparam logic [15:0] ASP_BAUD_HIGH = 16'h7052;
  localparam logic [15:0] ASP_BAUD_LOW = 16'h7053;
  localparam logic [15:0] ASP_CONTROL_TWO = 16'h7054;
  localparam logic [15:0] ASP_RX_STATUS = 16'h7055;
  localparam logic [15:0] ASP_RX_EMU = 16'h7056;
  localparam logic [15:0] ASP_RX_DATA = 16'h7057;
  localparam logic [15:0] ASP_TX_DATA = 16'h7059;
  localparam logic [15:0] ASP_FIFO_TX = 16'h705a;
  localparam logic [15:0] ASP_FIFO_RX = 16'h705b;
  localparam logic [15:0] ASP_FIFO_CT = 16'h705c;
  localparam logic [15:0] ASP_PRIORITY = 16'h705f;
  localparam logic [7:0] ASP_REG_RESET = 8'h00;
  localparam int ASP_CCR_STOP2 = 7;
  localparam int ASP_CCR_ODD = 6;
  localparam int ASP_CCR_PAREN = 5;
  localparam int ASP_CCR_ADDRMODE = 3;
  localparam int ASP_CTL1_ERRIE = 6;
  localparam int ASP_CTL1_RUN = 5;
  localparam int ASP_CTL1_TXWAKE = 3;
  localparam int ASP_CTL1_SLEEP = 2;
  localparam int ASP_CTL1_TXEN = 1;
  localparam int ASP_CTL1_RXEN = 0;
  localparam int ASP_FF_EN = 6;
  localparam int ASP_FF_CLR = 6;
  localparam int ASP_ABD_EN = 5;
  localparam logic [2:0] ASP_TICK_CENTRE = 3'h3;
  localparam logic [2:0] ASP_TICK_LAST = 3'h7;
  localparam logic [7:0] ASP_IDLE_TICKS = 8'h50;
  localparam logic [3:0] ASP_IDLE_BITS = 4'hb;
  localparam logic [2:0] ASP_FIFO_DEPTH = 3'h4;
endpackage

// file: asp_serial_port_props.sv
// Purpose: Port-level checks of the async serial port
// Assumes: One clock, synchronous active low reset
// Notes: Bound to every asp_serial_port instance
`timescale 1ns/1ns
module asp_serial_port_props
  import asp_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] wdata_i,
  input wire logic [15:0] rdata_o,
  input wire logic serial_rx_pin_i,
  input wire logic serial_tx_pin_o,
  input wire logic rx_int_o,
  input wire logic tx_int_o
);
  logic [7:0] run;
  logic c2tx, c2rx, errie, seen;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      run <= 8'hff;
      c2tx <= 1'b0;
      c2rx <= 1'b0;
      errie <= 1'b0;
      seen <= 1'b0;
    end else begin
      run <= $changed(serial_tx_pin_o) ? 8'h00 : run + {7'h0, run != 8'hff};
      if (wr_i && addr_i == ASP_CONTROL_TWO) begin
        c2tx <= wdata_i[0];
        c2rx <= wdata_i[1];
      end
      if (wr_i && addr_i == ASP_CONTROL_ONE) begin
        errie <= wdata_i[ASP_CTL1_ERRIE];
      end
      if (wr_i && addr_i == ASP_TX_DATA) begin
        seen <= 1'b1;
      end
    end
  end
  sequence s_halt;
    wr_i && addr_i == ASP_CONTROL_ONE && !wdata_i[ASP_CTL1_RUN];
  endsequence
  sequence s_bad_read;
    rd_i && (addr_i[15:4] != 12'h705 || addr_i[3:0] inside {4'h8, 4'hd, 4'he});
  endsequence
  a_reset_quiet: assert property ($rose(reset_n_i) |-> serial_tx_pin_o && rdata_o == 16'h0 && !rx_int_o && !tx_int_o)
    else $error("outputs not idle after reset");
  a_rdata_idle_zero: assert property (!rd_i |=> rdata_o == 16'h0)
    else $error("read data without a read");
  a_read_upper_zero: assert property (rd_i |=> rdata_o[15:8] == 8'h00)
    else $error("upper read byte not zero");
  a_unmapped_read_zero: assert property (s_bad_read |=> rdata_o == 16'h0)
    else $error("unmapped read not zero");
  a_bit_time_min: assert property ($changed(serial_tx_pin_o) |-> run >= 8'd15)
    else $error("transmit bit shorter than 16 clocks");
  a_tx_after_write: assert property ($fell(serial_tx_pin_o) |-> seen)
    else $error("start bit without a written char");
  a_halt_clears_int: assert property (s_halt |-> ##[1:3] !rx_int_o)
    else $error("receive interrupt survives software reset");
  a_rx_int_enable: assert property (rx_int_o |-> c2rx || errie || $past(c2rx) || $past(errie))
    else $error("receive interrupt while disabled");
  a_tx_int_enable: assert property (tx_int_o |-> c2tx || $past(c2tx))
    else $error("transmit interrupt while disabled");
endmodule
bind asp_serial_port asp_serial_port_props chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
  .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .serial_rx_pin_i(serial_rx_pin_i),
  .serial_tx_pin_o(serial_tx_pin_o), .rx_int_o(rx_int_o), .tx_int_o(tx_int_o));

// file: asp_peer.sv
// Purpose: Far-end serial peer sending and decoding characters
// Assumes: Bit time of BIT clocks
// Notes: Decodes 8 data bits plus the stop level
`timescale 1ns/1ns
module asp_peer #(
  parameter int BIT = 16
) (
  input wire logic clk_i,
  input wire logic tx_i,
  output logic rx_o,
  output logic got_o,
  output logic [8:0] data_o
);
  initial begin
    rx_o = 1'b1;
    got_o = 1'b0;
    data_o = 9'h0;
  end
  task automatic send(input logic [9:0] bits, input int n);
    @(posedge clk_i) rx_o <= 1'b0;
    repeat (BIT) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      rx_o <= bits[i];
      repeat (BIT) @(posedge clk_i);
    end
    rx_o <= 1'b1;
    repeat (3 * BIT) @(posedge clk_i);
  endtask
  always begin
    @(negedge tx_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge clk_i);
      data_o[i] = tx_i;
    end
    got_o = 1'b1;
    @(posedge clk_i) got_o = 1'b0;
  end
endmodule

// file: tb.sv
// Purpose: Self-checking bench of the async serial port
// Assumes: Divisor zero, so 16 clocks a bit
// Notes: Read and transmit results checked from queues
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
  import asp_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [15:0] addr_i = 16'h0;
  logic [15:0] wdata_i = 16'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic rd_q = 1'b0;
  logic [15:0] rdata_o;
  logic rx_pin, tx_pin, rx_int, tx_int, got;
  logic [8:0] got_d, m;
  logic [31:0] n;
  logic [7:0] rnd = 8'h32;
  logic [31:0] rq[$];
  logic [8:0] tq[$];
  logic [15:0] regs[7] = '{ASP_COMMS_CONTROL, ASP_CONTROL_ONE, ASP_BAUD_HIGH, ASP_BAUD_LOW, ASP_RX_STATUS,
    ASP_PRIORITY, 16'h7058};
  int fail_count = 0;
  int cmp_count = 0;
  always #2 clk_i = ~clk_i;
  asp_serial_port uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .serial_rx_pin_i(rx_pin), .serial_tx_pin_o(tx_pin),
    .rx_int_o(rx_int), .tx_int_o(tx_int));
  asp_peer peer (.clk_i(clk_i), .tx_i(tx_pin), .rx_o(rx_pin), .got_o(got), .data_o(got_d));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(negedge clk_i);
    addr_i = a;
    wdata_i = v;
    wr_i = 1'b1;
    @(negedge clk_i);
    wr_i = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic [15:0] k);
    rq.push_back({e, k});
    @(negedge clk_i);
    addr_i = a;
    rd_i = 1'b1;
    @(negedge clk_i);
    rd_i = 1'b0;
  endtask
  task automatic bound(input int lim, input bit fall);
    int i;
    for (i = 0; i < lim; i++) begin
      if (fall ? tx_pin === 1'b0 : tq.size() == 0) break;
      @(negedge clk_i);
    end
    if (i == lim) begin
      fail_count++;
      print_verdict();
    end
  endtask
  always @(posedge clk_i) rd_q <= rd_i;
  always @(negedge clk_i) begin
    if (rd_q) begin
      n = rq.pop_front();
      `CHK(rdata_o & n[15:0], n[31:16])
    end
  end
  always @(posedge got) begin
    m = tq.pop_front();
    `CHK(got_d, m)
  end
  initial begin
    repeat (4) @(negedge clk_i);
    reset_n_i = 1'b1;
    foreach (regs[i]) rd(regs[i], {8'h00, ASP_REG_RESET}, 16'hffff);
    wr(ASP_BAUD_LOW, 16'hff5a);
    rd(ASP_BAUD_LOW, 16'h005a, 16'hffff);
    wr(ASP_BAUD_LOW, 16'h0000);
    wr(ASP_COMMS_CONTROL, 16'h0007);
    wr(ASP_CONTROL_TWO, 16'h0003);
    wr(ASP_CONTROL_ONE, 16'h0023);
    for (int k = 0; k < 2; k++) begin
      rnd = lfsr(rnd);
      tq.push_back({1'b1, rnd});
      wr(ASP_TX_DATA, {8'h00, rnd});
      bound(200, 1'b1);
    end
    bound(2000, 1'b0);
    repeat (16) @(negedge clk_i);
    rd(ASP_CONTROL_TWO, 16'h00c3, 16'hffff);
    rnd = lfsr(rnd);
    peer.send({2'b11, rnd}, 8);
    rd(ASP_RX_STATUS, 16'h0040, 16'hfffd);
    rd(ASP_RX_EMU, {8'h00, rnd}, 16'hffff);
    rd(ASP_RX_DATA, {8'h00, rnd}, 16'hffff);
    peer.send(10'h3ff, 8);
    peer.send(10'h355, 8);
    rd(ASP_RX_STATUS, 16'h0088, 16'h0088);
    for (int k = 0; k < 4; k++) begin
      wr(ASP_CONTROL_ONE, 16'h0003);
      wr(ASP_CONTROL_ONE, 16'h0023);
      rd(ASP_RX_STATUS, 16'h0000, 16'hffff);
      rnd = lfsr(rnd);
      wr(ASP_COMMS_CONTROL, {8'h00, {2{k[1]}}, 6'h27});
      peer.send({1'b1, ^rnd ^ k[1] ^ k[0], rnd}, 9);
      rd(ASP_RX_STATUS, k[0] ? 16'h0084 : 16'h0000, 16'h0084);
    end
    wr(ASP_CONTROL_ONE, 16'h0003);
    wr(ASP_CONTROL_ONE, 16'h0023);
    wr(ASP_COMMS_CONTROL, 16'h0007);
    wr(ASP_FIFO_TX, 16'h0040);
    wr(ASP_FIFO_CT, 16'h0020);
    peer.send({2'b11, 8'h01}, 8);
    rd(ASP_FIFO_CT, 16'h00a0, 16'hffff);
    rd(ASP_BAUD_LOW, 16'h0001, 16'hffff);
    peer.send(10'h000, 10);
    rd(ASP_RX_STATUS, 16'h00b0, 16'h00b0);
    rd(ASP_FIFO_RX, 16'h0002, 16'h0087);
    rd(ASP_RX_DATA, 16'h0001, 16'hffff);
    rd(ASP_RX_DATA, 16'h0000, 16'hffff);
    repeat (4) @(negedge clk_i);
    print_verdict();
  end
endmodule
